// ---- design/htc_map.vh ----
`ifndef HTC_MAP_VH
`define HTC_MAP_VH
// Purpose: register offsets, fields, modes, resets and bus responses for the 16-bit timer/counter
// Assumes: AXI4-Lite, 32-bit data, one word per register
// Notes:   all offsets are byte addresses
`define HTC_OFS_CTRL      8'h00
`define HTC_OFS_PRESC     8'h04
`define HTC_OFS_TOP       8'h08
`define HTC_OFS_CMP       8'h0C
`define HTC_OFS_CNT       8'h10
`define HTC_OFS_CAPT      8'h14
`define HTC_OFS_STAT      8'h18
`define HTC_OFS_MASK      8'h1C
// control fields
`define HTC_CTRL_EN       0
`define HTC_CTRL_MODE_LO  1
`define HTC_CTRL_MODE_HI  2
`define HTC_CTRL_SRC      3
`define HTC_CTRL_CAPEN    4
`define HTC_CTRL_INV      5
`define HTC_CTRL_RSTEN    6
`define HTC_CTRL_BUSEN    7
// modes
`define HTC_MODE_WDOG     2'h0
`define HTC_MODE_CTC      2'h1
`define HTC_MODE_FPWM     2'h2
`define HTC_MODE_PFC      2'h3
// status bits
`define HTC_ST_OVF        0
`define HTC_ST_CMP        1
`define HTC_ST_CAP        2
// reset values
`define HTC_CTRL_RST      8'h41
`define HTC_PRESC_RST     16'h0000
`define HTC_TOP_RST       16'hFFFF
`define HTC_CMP_RST       16'h8000
`define HTC_ALL_ONES      16'hFFFF
// AXI responses
`define HTC_RESP_OKAY     2'b00
`define HTC_RESP_SLVERR   2'b10
`endif

// ---- design/htc_sync.v ----
// Purpose: three-stage synchroniser with agreement filter for an outside level
// Assumes: input asynchronous to clk
// Notes:   stage one is read only by stage two
module htc_sync (
    input  wire clk,
    input  wire sys_rst,
    input  wire async_in,
    output reg  level_ff
);
    reg s1_ff;
    reg s2_ff;
    reg s3_ff;

    always @(posedge clk) begin
        if (sys_rst) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            // change counts only once the two late stages agree
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end
endmodule

// ---- design/htc_timer.v ----
// Purpose: bidirectional 16-bit timer/counter with compare, PWM, capture and irq
// Assumes: one clock; timer_input_clock and capture pin are asynchronous inputs
// Notes:   AXI4-Lite slave, one write and one read outstanding at a time
// Summary of operation
// - one 16-bit up/down counter with compare unit
// - watchdog, clear-on-match, fast PWM, phase-correct PWM
// - selectable count source through programmable prescaler
// - overflow, compare and capture interrupt sources
// - synchronised rising capture edge latches count when capture is enabled, outside PWM modes, with bus used
// - without bus irq is overflow; else masked
// - static irq plus separate wake-up irq
// - glitch-free PWM, period changes without spurious pulses
// - waveform driven by mode and compare result
// - registers read and written over bus slave
// - stand-alone preloaded mode keeps reset pin enabled
`include "htc_map.vh"
module htc_timer #(
    parameter [7:0]  CTRL_PRELOAD  = `HTC_CTRL_RST,
    parameter [15:0] PRESC_PRELOAD = `HTC_PRESC_RST,
    parameter [15:0] TOP_PRELOAD   = `HTC_TOP_RST,
    parameter [15:0] CMP_PRELOAD   = `HTC_CMP_RST
) (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        timer_input_clock,
    input  wire        timer_reset_n,
    input  wire        capture_trigger_in,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         timer_irq_out,
    output reg         timer_wake_irq_out,
    output reg         timer_wave_out
);
    // ****************************************
    // input synchronisers
    // ****************************************
    wire tclk_lvl;
    wire cap_lvl;
    wire rst_pin_lvl;

    htc_sync u_sync_tclk (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (timer_input_clock),
        .level_ff (tclk_lvl)
    );
    htc_sync u_sync_cap (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (capture_trigger_in),
        .level_ff (cap_lvl)
    );
    htc_sync u_sync_rst (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (~timer_reset_n),
        .level_ff (rst_pin_lvl)
    );

    // ****************************************
    // registers
    // ****************************************
    reg  [7:0]  ctrl_ff;
    reg  [15:0] presc_ff;
    reg  [15:0] top_ff;
    reg  [15:0] cmp_ff;
    reg  [15:0] top_act_ff;
    reg  [15:0] cmp_act_ff;
    reg  [15:0] counter_value;
    reg  [15:0] capture_value_reg;
    reg  [15:0] presc_cnt_ff;
    reg  [2:0]  stat_ff;
    reg  [2:0]  mask_ff;
    reg         dir_down_ff;
    reg         tclk_d_ff;
    reg         cap_d_ff;
    reg  [7:0]  awaddr_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         aw_have_ff;
    reg         w_have_ff;

    wire [1:0]  mode       = ctrl_ff[`HTC_CTRL_MODE_HI:`HTC_CTRL_MODE_LO];
    wire        pwm_mode   = mode[1];
    wire        timer_reset_pin_enable = ctrl_ff[`HTC_CTRL_RSTEN];
    wire        bus_used   = ctrl_ff[`HTC_CTRL_BUSEN];
    // reset pin forced effective when bus unused
    wire        pin_rst    = rst_pin_lvl & (timer_reset_pin_enable | ~bus_used);

    // ****************************************
    // prescaler and count tick
    // ****************************************
    wire src_evt = ctrl_ff[`HTC_CTRL_SRC] ? (tclk_lvl & ~tclk_d_ff) : 1'b1;
    wire presc_done = (presc_cnt_ff == presc_ff);
    wire tick = ctrl_ff[`HTC_CTRL_EN] & src_evt & presc_done;

    // ****************************************
    // counter next state
    // ****************************************
    reg  [15:0] nxt_counter;
    reg         nxt_dir_down;
    reg         ovf_evt;
    reg         cmp_evt;
    reg         period_end;

    always @* begin
        nxt_counter  = counter_value;
        nxt_dir_down = dir_down_ff;
        ovf_evt      = 1'b0;
        cmp_evt      = 1'b0;
        period_end   = 1'b0;
        if (tick) begin
            case (mode)
                `HTC_MODE_WDOG: begin
                    nxt_counter = counter_value + 16'h0001;
                    if (counter_value == `HTC_ALL_ONES) begin
                        ovf_evt = 1'b1;
                    end
                end
                `HTC_MODE_CTC: begin
                    if (counter_value == cmp_act_ff) begin
                        nxt_counter = 16'h0000;
                        cmp_evt     = 1'b1;
                    end else begin
                        nxt_counter = counter_value + 16'h0001;
                    end
                    if (counter_value == `HTC_ALL_ONES) begin
                        ovf_evt = 1'b1;
                    end
                end
                `HTC_MODE_FPWM: begin
                    if (counter_value >= top_act_ff) begin
                        nxt_counter = 16'h0000;
                        ovf_evt     = 1'b1;
                        period_end  = 1'b1;
                    end else begin
                        nxt_counter = counter_value + 16'h0001;
                    end
                    if (counter_value == cmp_act_ff) begin
                        cmp_evt = 1'b1;
                    end
                end
                default: begin
                    // counts up to top then back down; direction flips at ends
                    if (!dir_down_ff) begin
                        if (counter_value >= top_act_ff) begin
                            nxt_dir_down = 1'b1;
                            nxt_counter  = counter_value - 16'h0001;
                        end else begin
                            nxt_counter = counter_value + 16'h0001;
                        end
                    end else begin
                        if (counter_value == 16'h0000) begin
                            nxt_dir_down = 1'b0;
                            nxt_counter  = 16'h0001;
                            ovf_evt      = 1'b1;
                            period_end   = 1'b1;
                        end else begin
                            nxt_counter = counter_value - 16'h0001;
                        end
                    end
                    if (counter_value == cmp_act_ff) begin
                        cmp_evt = 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // capture edge
    // ****************************************
    wire cap_evt = ctrl_ff[`HTC_CTRL_CAPEN] & ~pwm_mode & bus_used &
                   cap_lvl & ~cap_d_ff;

    // ****************************************
    // bus decode
    // ****************************************
    wire        aw_fire = s_axi_awvalid & s_axi_awready;
    wire        w_fire  = s_axi_wvalid & s_axi_wready;
    wire        aw_ok   = aw_have_ff | aw_fire;
    wire        w_ok    = w_have_ff | w_fire;
    wire [7:0]  wr_addr = aw_have_ff ? awaddr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_have_ff ? wdata_ff : s_axi_wdata;
    wire [3:0]  wr_strb = w_have_ff ? wstrb_ff : s_axi_wstrb;
    wire        wr_go   = aw_ok & w_ok & ~s_axi_bvalid;
    wire [15:0] wr_m16  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire        wr_hit  = (wr_addr == `HTC_OFS_CTRL) | (wr_addr == `HTC_OFS_PRESC) |
                          (wr_addr == `HTC_OFS_TOP) | (wr_addr == `HTC_OFS_CMP) |
                          (wr_addr == `HTC_OFS_CNT) | (wr_addr == `HTC_OFS_CAPT) |
                          (wr_addr == `HTC_OFS_STAT) | (wr_addr == `HTC_OFS_MASK);
    wire        w_stat  = wr_go & (wr_addr == `HTC_OFS_STAT) & wr_strb[0];
    wire        w_cnt   = wr_go & (wr_addr == `HTC_OFS_CNT);
    wire [2:0]  stat_set = {cap_evt, cmp_evt, ovf_evt};
    wire [2:0]  stat_clr = w_stat ? wr_data[2:0] : 3'b000;

    reg  [31:0] rd_mux;
    reg         rd_hit;
    always @* begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `HTC_OFS_CTRL:  rd_mux = {24'h00_0000, ctrl_ff};
            `HTC_OFS_PRESC: rd_mux = {16'h0000, presc_ff};
            `HTC_OFS_TOP:   rd_mux = {16'h0000, top_ff};
            `HTC_OFS_CMP:   rd_mux = {16'h0000, cmp_ff};
            `HTC_OFS_CNT:   rd_mux = {16'h0000, counter_value};
            `HTC_OFS_CAPT:  rd_mux = {16'h0000, capture_value_reg};
            `HTC_OFS_STAT:  rd_mux = {29'h0000_0000, stat_ff};
            `HTC_OFS_MASK:  rd_mux = {29'h0000_0000, mask_ff};
            default:        rd_hit = 1'b0;
        endcase
    end

    // ****************************************
    // sequential
    // ****************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            ctrl_ff           <= CTRL_PRELOAD;
            presc_ff          <= PRESC_PRELOAD;
            top_ff            <= TOP_PRELOAD;
            cmp_ff            <= CMP_PRELOAD;
            top_act_ff        <= TOP_PRELOAD;
            cmp_act_ff        <= CMP_PRELOAD;
            counter_value     <= 16'h0000;
            capture_value_reg <= 16'h0000;
            presc_cnt_ff      <= 16'h0000;
            stat_ff           <= 3'b000;
            mask_ff           <= 3'b000;
            dir_down_ff       <= 1'b0;
            tclk_d_ff         <= 1'b0;
            cap_d_ff          <= 1'b0;
            aw_have_ff        <= 1'b0;
            w_have_ff         <= 1'b0;
            awaddr_ff         <= 8'h00;
            wdata_ff          <= 32'h0000_0000;
            wstrb_ff          <= 4'h0;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `HTC_RESP_OKAY;
            s_axi_arready     <= 1'b0;
            s_axi_rvalid      <= 1'b0;
            s_axi_rresp       <= `HTC_RESP_OKAY;
            s_axi_rdata       <= 32'h0000_0000;
            timer_irq_out     <= 1'b0;
            timer_wake_irq_out <= 1'b0;
            timer_wave_out    <= 1'b0;
        end else begin
            tclk_d_ff <= tclk_lvl;
            cap_d_ff  <= cap_lvl;
            if (src_evt) begin
                presc_cnt_ff <= presc_done ? 16'h0000 : presc_cnt_ff + 16'h0001;
            end
            // write channel: address and data taken in either order
            s_axi_awready <= ~aw_ok & ~s_axi_awready;
            s_axi_wready  <= ~w_ok & ~s_axi_wready;
            if (aw_fire) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            aw_have_ff <= aw_ok & ~wr_go;
            w_have_ff  <= w_ok & ~wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `HTC_RESP_OKAY : `HTC_RESP_SLVERR;
                case (wr_addr)
                    `HTC_OFS_CTRL:  if (wr_strb[0]) ctrl_ff <= wr_data[7:0];
                    `HTC_OFS_PRESC: presc_ff <= (presc_ff & ~wr_m16) | (wr_data[15:0] & wr_m16);
                    `HTC_OFS_TOP:   top_ff <= (top_ff & ~wr_m16) | (wr_data[15:0] & wr_m16);
                    `HTC_OFS_CMP:   cmp_ff <= (cmp_ff & ~wr_m16) | (wr_data[15:0] & wr_m16);
                    `HTC_OFS_MASK:  if (wr_strb[0]) mask_ff <= wr_data[2:0];
                    default:        ;
                endcase
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // read channel
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `HTC_RESP_OKAY : `HTC_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            // compare/top shadow: PWM loads only at period end, others at once
            if (!pwm_mode || period_end) begin
                top_act_ff <= top_ff;
                cmp_act_ff <= cmp_ff;
            end
            if (pin_rst) begin
                counter_value <= 16'h0000;
                dir_down_ff   <= 1'b0;
                stat_ff       <= 3'b000;
            end else begin
                if (w_cnt) begin
                    counter_value <= wr_data[15:0];
                end else begin
                    counter_value <= nxt_counter;
                end
                dir_down_ff <= nxt_dir_down;
                // set wins over a same-cycle clear
                stat_ff <= (stat_ff & ~stat_clr) | stat_set;
            end
            if (cap_evt) begin
                capture_value_reg <= counter_value;
            end
            if (bus_used) begin
                timer_irq_out <= |(stat_ff & mask_ff);
            end else begin
                timer_irq_out <= stat_ff[`HTC_ST_OVF];
            end
            timer_wake_irq_out <= |(stat_ff & mask_ff) | (~bus_used & stat_ff[`HTC_ST_OVF]);
            // waveform from mode and compare result
            case (mode)
                `HTC_MODE_FPWM: timer_wave_out <= ctrl_ff[`HTC_CTRL_INV] ^
                                                  (counter_value < cmp_act_ff);
                `HTC_MODE_PFC:  timer_wave_out <= ctrl_ff[`HTC_CTRL_INV] ^
                                                  (counter_value < cmp_act_ff);
                default:        if (cmp_evt) timer_wave_out <= ~timer_wave_out;
            endcase
        end
    end
endmodule

// ---- tb/htc_timer_sva.sv ----
// Purpose: port-level checks of the timer's bus slave, irq and reset
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into htc_timer after the module
module htc_timer_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        timer_irq_out,
    input wire logic        timer_wake_irq_out,
    input wire logic        timer_wave_out
);
    // ****************************************
    // bus and interrupt properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_wr_req;
        $rose(s_axi_awvalid) && s_axi_wvalid;
    endsequence
    sequence s_rd_walk;
        ##1 s_axi_arready ##1 s_axi_rvalid;
    endsequence
    a_aw_single_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than one cycle");
    a_b_within_bound: assert property (s_wr_req |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    a_b_holds_resp: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_b_released: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rd_walk: assert property ($rose(s_axi_arvalid) |-> s_rd_walk)
        else $error("read walk broken");
    a_r_holds_data: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_wake_matches_irq: assert property (timer_wake_irq_out == timer_irq_out)
        else $error("wake irq differs from irq");
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
        !s_axi_bvalid && !s_axi_rvalid && !timer_irq_out && !timer_wave_out)
        else $error("outputs active after reset");
endmodule
bind htc_timer htc_timer_sva chk_u (.clk(clk), .sys_rst(sys_rst),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .timer_irq_out(timer_irq_out),
    .timer_wake_irq_out(timer_wake_irq_out), .timer_wave_out(timer_wave_out));

// ---- tb/htc_axi_master.sv ----
// Purpose: fabric-side bus master model for the timer registers
// Assumes: AXI4-Lite, one write and one read outstanding
// Notes:   waits for answers without a bound; the bench watchdog cuts hangs
module htc_axi_master (
    input  wire logic        clk,
    output logic [7:0]  awaddr,
    output logic        awvalid,
    input  wire logic        awready,
    output logic [31:0] wdata,
    output logic [3:0]  wstrb,
    output logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic        bready,
    output logic [7:0]  araddr,
    output logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic        rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // channel tasks
    // ****************************************
    initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    task automatic wr(input [7:0] a, input [31:0] d, output [1:0] r);
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'h3;
        wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            // released data no longer shows the last word
            if (wready) begin wvalid <= 1'b0; wdata <= ~d; end
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule

// ---- tb/htc_timer_bench.sv ----
// Purpose: register-level tests of the 16-bit timer/counter
// Assumes: 250 MHz clock, reset held six cycles
// Notes:   expectations follow the register map header
`include "htc_map.vh"
module htc_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, tclk = 0, trst_n = 1, capt = 0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, wake, wave;
    int n_errors = 0, checks = 0, e;
    `define CHK(nm, ex, s) begin checks++; if ((s) !== (ex)) begin n_errors++; \
        $display("[ERR] %s exp %0h got %0h", nm, ex, s); end end
    always #2 clk = ~clk;
    htc_axi_master mst_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    htc_timer dut_u (.clk(clk), .sys_rst(sys_rst), .timer_input_clock(tclk),
        .timer_reset_n(trst_n), .capture_trigger_in(capt), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_irq_out(irq), .timer_wake_irq_out(wake),
        .timer_wave_out(wave));
    // ****************************************
    // access and helper tasks
    // ****************************************
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] er = `HTC_RESP_OKAY);
        mst_u.wr(a, d, rr);
        `CHK("bresp", er, rr)
    endtask
    task automatic rd(input [7:0] a, input [31:0] ex, input [1:0] er = `HTC_RESP_OKAY);
        mst_u.rd(a, rv, rr);
        `CHK("rresp", er, rr)
        `CHK("rdata", ex, rv)
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (8) @(posedge clk);
            tclk <= 1'b1;
            repeat (8) @(posedge clk);
            tclk <= 1'b0;
        end
        repeat (10) @(posedge clk);
    endtask
    task automatic edges(input int n);
        logic prev;
        // sample mid-cycle, away from the edge that launches the wave
        @(negedge clk);
        prev = wave;
        e = 0;
        repeat (n) begin
            @(negedge clk);
            if (wave && !prev) e++;
            prev = wave;
        end
    endtask
    task automatic complete_run;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        #100us;
        n_errors++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`HTC_OFS_CTRL, 32'h0000_0041);
        rd(`HTC_OFS_PRESC, 32'h0000_0000);
        rd(`HTC_OFS_TOP, 32'h0000_FFFF);
        rd(`HTC_OFS_CMP, 32'h0000_8000);
        rd(8'h20, 32'h0000_0000, `HTC_RESP_SLVERR);
        wr(8'h24, 32'h0000_00FF, `HTC_RESP_SLVERR);
        // stand-alone: irq shows the overflow flag directly
        wr(`HTC_OFS_CTRL, 32'h0000_0001);
        wr(`HTC_OFS_CNT, 32'h0000_FFF0);
        repeat (40) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        wr(`HTC_OFS_CTRL, 32'h0000_0081);
        wr(`HTC_OFS_MASK, 32'h0000_0000);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        rd(`HTC_OFS_STAT, 32'h0000_0001);
        wr(`HTC_OFS_MASK, 32'h0000_0001);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b1, irq)
        wr(`HTC_OFS_STAT, 32'h0000_0001);
        repeat (3) @(posedge clk);
        `CHK("irq", 1'b0, irq)
        // external source, undivided then divided by four
        wr(`HTC_OFS_CTRL, 32'h0000_0080);
        wr(`HTC_OFS_PRESC, 32'h0000_0000);
        wr(`HTC_OFS_CNT, 32'h0000_0000);
        wr(`HTC_OFS_CTRL, 32'h0000_0089);
        pulses(5);
        rd(`HTC_OFS_CNT, 32'h0000_0005);
        wr(`HTC_OFS_CTRL, 32'h0000_0080);
        wr(`HTC_OFS_CNT, 32'h0000_0000);
        wr(`HTC_OFS_PRESC, 32'h0000_0003);
        wr(`HTC_OFS_CTRL, 32'h0000_0089);
        pulses(8);
        rd(`HTC_OFS_CNT, 32'h0000_0002);
        // stopped counter makes the captured stamp exact
        wr(`HTC_OFS_CTRL, 32'h0000_0080);
        wr(`HTC_OFS_PRESC, 32'h0000_0000);
        wr(`HTC_OFS_CNT, 32'h0000_1234);
        wr(`HTC_OFS_STAT, 32'h0000_0007);
        wr(`HTC_OFS_CTRL, 32'h0000_0090);
        capt <= 1'b1;
        repeat (12) @(posedge clk);
        rd(`HTC_OFS_CAPT, 32'h0000_1234);
        rd(`HTC_OFS_STAT, 32'h0000_0004);
        capt <= 1'b0;
        // pwm periods: fast is top+1, dual-slope is 2*top
        wr(`HTC_OFS_CTRL, 32'h0000_0080);
        wr(`HTC_OFS_CNT, 32'h0000_FFF0);
        wr(`HTC_OFS_TOP, 32'h0000_0009);
        wr(`HTC_OFS_CMP, 32'h0000_0004);
        wr(`HTC_OFS_CTRL, 32'h0000_0085);
        repeat (40) @(posedge clk);
        edges(100);
        `CHK("fast edges", 10, e)
        wr(`HTC_OFS_CTRL, 32'h0000_0087);
        repeat (40) @(posedge clk);
        edges(180);
        `CHK("pfc edges", 10, e)
        // period change while running: new top takes effect at the bottom
        wr(`HTC_OFS_TOP, 32'h0000_0013);
        repeat (60) @(posedge clk);
        edges(380);
        `CHK("pfc new top edges", 10, e)
        // clear-on-match: wave toggles every cmp+1 ticks
        wr(`HTC_OFS_CTRL, 32'h0000_0080);
        wr(`HTC_OFS_CNT, 32'h0000_0000);
        wr(`HTC_OFS_CTRL, 32'h0000_0083);
        repeat (40) @(posedge clk);
        edges(100);
        `CHK("ctc edges", 10, e)
        // reset pin clears count and flags
        wr(`HTC_OFS_CTRL, 32'h0000_00C0);
        wr(`HTC_OFS_CNT, 32'h0000_0055);
        trst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rd(`HTC_OFS_CNT, 32'h0000_0000);
        rd(`HTC_OFS_STAT, 32'h0000_0000);
        trst_n <= 1'b1;
        complete_run;
    end
endmodule
